/* verilog/vip_bank.sv */
// Virtual interrupt injection and power control register bank
`timescale 1ns/10ps
`include "vip_regs.svh"

module vip_bank
#(
   parameter int LAT_W = 3
)
(
   // Clock, reset, enable
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_ce,
   // Coprocessor transfer request
   input wire logic i_cp_valid,
   input wire logic i_cp_write,
   input wire logic [3:0] i_cp_crn,
   input wire logic [3:0] i_cp_crm,
   input wire logic [2:0] i_cp_op1,
   input wire logic [2:0] i_cp_op2,
   input wire logic [31:0] i_cp_wdata,
   // Processor state
   input wire logic i_secure,
   input wire logic i_priv,
   // Configuration pins
   input wire logic [LAT_W-1:0] i_max_clock_latency_pins,
   // Transfer answer
   output logic o_cp_ack,
   output logic o_cp_undef,
   output logic [31:0] o_cp_rdata,
   // Virtual events to the core
   output logic o_virt_abort,
   output logic o_virt_irq,
   output logic o_virt_fiq,
   // Power control
   output logic o_clk_gate_en,
   output logic [LAT_W-1:0] o_max_clk_latency
);

   // ==========================================
   // Elaboration check
   if (LAT_W != (`VIP_PWR_LAT_MSB - `VIP_PWR_LAT_LSB + 1))
   begin : g_bad_width
      $error("LAT_W must match the latency field width");
   end

   // ==========================================
   // Decode
   vip_pkg::vip_sel_t sel;
   logic inj_allowed;
   logic req;
   logic inj_wr;
   logic pwr_wr;

   vip_cp_decode u_dec
   (
      .i_crn(i_cp_crn),
      .i_crm(i_cp_crm),
      .i_op1(i_cp_op1),
      .i_op2(i_cp_op2),
      .o_sel(sel)
   );

   assign req = i_cp_valid & i_ce;
   assign inj_allowed = i_secure & i_priv;
   assign inj_wr = req & i_cp_write & (sel == vip_pkg::VIP_SEL_INJ) & inj_allowed;
   // User mode may read but not change the power register
   assign pwr_wr = req & i_cp_write & (sel == vip_pkg::VIP_SEL_PWR) & i_secure
                   & i_priv;

   // ==========================================
   // Register state
   logic [2:0] inj_r;
   logic [2:0] inj_nxt;
   logic gate_r;
   logic gate_nxt;
   logic [LAT_W-1:0] lat_r;
   logic [LAT_W-1:0] lat_nxt;
   logic strap_pend_r;
   logic strap_pend_nxt;

   always_comb
   begin
      inj_nxt = inj_r;
      gate_nxt = gate_r;
      lat_nxt = lat_r;
      strap_pend_nxt = strap_pend_r;
      // Pins are caught on the first enabled edge after reset release
      if (strap_pend_r)
      begin
         lat_nxt = i_max_clock_latency_pins;
         strap_pend_nxt = 1'b0;
      end
      if (inj_wr)
      begin
         // Only the three event bits are stored; the rest is dropped
         inj_nxt[vip_pkg::VIP_EV_ABORT] = i_cp_wdata[`VIP_INJ_ABORT_BIT];
         inj_nxt[vip_pkg::VIP_EV_IRQ] = i_cp_wdata[`VIP_INJ_IRQ_BIT];
         inj_nxt[vip_pkg::VIP_EV_FIQ] = i_cp_wdata[`VIP_INJ_FIQ_BIT];
      end
      if (pwr_wr)
      begin
         gate_nxt = i_cp_wdata[`VIP_PWR_GATE_BIT];
         // A write wins over a pending strap load only if it comes later
         if (!strap_pend_r)
         begin
            lat_nxt = i_cp_wdata[`VIP_PWR_LAT_MSB:`VIP_PWR_LAT_LSB];
         end
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         inj_r <= `VIP_INJ_RST;
         gate_r <= `VIP_GATE_RST;
         lat_r <= `VIP_LAT_RST;
         strap_pend_r <= 1'b1;
      end
      else if (i_ce)
      begin
         inj_r <= inj_nxt;
         gate_r <= gate_nxt;
         lat_r <= lat_nxt;
         strap_pend_r <= strap_pend_nxt;
      end
   end

   // ==========================================
   // Transfer answer
   logic ack_nxt;
   logic undef_nxt;
   logic [31:0] rdata_nxt;

   always_comb
   begin
      ack_nxt = req;
      undef_nxt = 1'b0;
      rdata_nxt = `VIP_WORD_ZERO;
      if (req)
      begin
         case (sel)
            vip_pkg::VIP_SEL_INJ:
            begin
               if (!inj_allowed)
               begin
                  undef_nxt = 1'b1;
               end
               else if (!i_cp_write)
               begin
                  rdata_nxt[`VIP_INJ_ABORT_BIT] = inj_r[vip_pkg::VIP_EV_ABORT];
                  rdata_nxt[`VIP_INJ_IRQ_BIT] = inj_r[vip_pkg::VIP_EV_IRQ];
                  rdata_nxt[`VIP_INJ_FIQ_BIT] = inj_r[vip_pkg::VIP_EV_FIQ];
               end
            end
            vip_pkg::VIP_SEL_PWR:
            begin
               if (!i_cp_write)
               begin
                  rdata_nxt[`VIP_PWR_LAT_MSB:`VIP_PWR_LAT_LSB] = lat_r;
                  rdata_nxt[`VIP_PWR_GATE_BIT] = gate_r;
               end
            end
            default:
            begin
               undef_nxt = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         o_cp_ack <= 1'b0;
         o_cp_undef <= 1'b0;
         o_cp_rdata <= `VIP_WORD_ZERO;
      end
      else if (i_ce)
      begin
         o_cp_ack <= ack_nxt;
         o_cp_undef <= undef_nxt;
         o_cp_rdata <= rdata_nxt;
      end
   end

   // ==========================================
   // Event delivery
   logic [2:0] take;
   logic [2:0] take_r;
   logic [2:0] take_nxt;

   vip_event_gate #(.N_EV(3)) u_gate
   (
      .i_pending(inj_r),
      .i_nonsecure(~i_secure),
      .o_take(take)
   );

   always_comb
   begin
      take_nxt = take;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         take_r <= `VIP_INJ_RST;
      end
      else if (i_ce)
      begin
         take_r <= take_nxt;
      end
   end

   assign o_virt_abort = take_r[vip_pkg::VIP_EV_ABORT];
   assign o_virt_irq = take_r[vip_pkg::VIP_EV_IRQ];
   assign o_virt_fiq = take_r[vip_pkg::VIP_EV_FIQ];
   assign o_clk_gate_en = gate_r;
   assign o_max_clk_latency = lat_r;

   // ==========================================
   // Checks
   logic abort_arm;
   logic irq_arm;
   logic fiq_arm;
   logic wd_abort;
   logic wd_gate;
   logic [LAT_W-1:0] wd_lat;

   assign abort_arm = inj_r[vip_pkg::VIP_EV_ABORT] & ~i_secure;
   assign irq_arm = inj_r[vip_pkg::VIP_EV_IRQ] & ~i_secure;
   assign fiq_arm = inj_r[vip_pkg::VIP_EV_FIQ] & ~i_secure;
   assign wd_abort = i_cp_wdata[`VIP_INJ_ABORT_BIT];
   assign wd_gate = i_cp_wdata[`VIP_PWR_GATE_BIT];
   assign wd_lat = i_cp_wdata[`VIP_PWR_LAT_MSB:`VIP_PWR_LAT_LSB];

   inj_block_undef_a: assert property (
      @(posedge i_clk) disable iff (i_srst)
      req && sel == vip_pkg::VIP_SEL_INJ && !inj_allowed |=> o_cp_ack && o_cp_undef)
      else $error("blocked virtual interrupt access not refused");

   inj_block_keep_a: assert property (
      @(posedge i_clk) disable iff (i_srst)
      req && i_cp_write && sel == vip_pkg::VIP_SEL_INJ && !inj_allowed |=> $stable(inj_r))
      else $error("blocked write changed virtual interrupt bits");

   abort_deliver_a: assert property (
      @(posedge i_clk) disable iff (i_srst)
      i_ce |=> o_virt_abort == $past(abort_arm))
      else $error("virtual abort not following pending bit and state");

   irq_deliver_a: assert property (
      @(posedge i_clk) disable iff (i_srst)
      i_ce |=> o_virt_irq == $past(irq_arm))
      else $error("virtual irq not following pending bit and state");

   fiq_deliver_a: assert property (
      @(posedge i_clk) disable iff (i_srst)
      i_ce |=> o_virt_fiq == $past(fiq_arm))
      else $error("virtual fiq not following pending bit and state");

   // The outputs follow the state seen at the previous enabled edge only
   secure_quiet_a: assert property (
      @(posedge i_clk) disable iff (i_srst)
      i_ce && i_secure |=> !o_virt_irq && !o_virt_fiq && !o_virt_abort)
      else $error("virtual event delivered in Secure state");

   inj_write_a: assert property (
      @(posedge i_clk) disable iff (i_srst)
      inj_wr |=> inj_r[vip_pkg::VIP_EV_ABORT] == $past(wd_abort))
      else $error("virtual interrupt write not stored");

   pwr_ns_keep_a: assert property (
      @(posedge i_clk) disable iff (i_srst)
      req && i_cp_write && sel == vip_pkg::VIP_SEL_PWR && !i_secure && !strap_pend_r
      |=> $stable(gate_r) && $stable(lat_r))
      else $error("Non-secure write changed power register");

   strap_load_a: assert property (
      @(posedge i_clk) disable iff (i_srst)
      i_ce && strap_pend_r |=> lat_r == $past(i_max_clock_latency_pins))
      else $error("latency pins not captured after reset");

   gate_reset_a: assert property (
      @(posedge i_clk)
      i_srst |=> !o_clk_gate_en && strap_pend_r)
      else $error("clock gating enabled out of reset");

   pwr_write_a: assert property (
      @(posedge i_clk) disable iff (i_srst)
      pwr_wr |=> o_clk_gate_en == $past(wd_gate))
      else $error("power register write not stored");

   pwr_lat_write_a: assert property (
      @(posedge i_clk) disable iff (i_srst)
      pwr_wr && !strap_pend_r |=> o_max_clk_latency == $past(wd_lat))
      else $error("power register latency write not stored");

   reserved_zero_a: assert property (
      @(posedge i_clk) disable iff (i_srst)
      o_cp_ack |-> (o_cp_rdata & ~(`VIP_INJ_MASK | `VIP_PWR_MASK)) == `VIP_WORD_ZERO)
      else $error("reserved read data bits not zero");

endmodule

/* shared/vip_regs.svh */
// Encodings, field positions and reset values of the virtual interrupt and power registers
// How it works
// - Virtual interrupt register answers only Secure privileged accesses; others get no access.
// - A pending virtual event reaches the core one enabled edge after it is Non-secure.
// - Abort bit [8] set while Non-secure raises an ordinary abort.
// - IRQ bit [7] set while Non-secure raises an ordinary IRQ.
// - FIQ bit [6] set while Non-secure raises an ordinary FIQ.
// - Virtual interrupt register sits at CRn c12, CRm c1, op1 0, op2 1.
// - Power register is written only in Secure state; Non-secure may read it.
// - Latency field [10:8] loads from the latency pins when reset ends.
// - Power bit [0] enables dynamic clock gating and clears at reset.
// - Power register sits at CRn c15, CRm c0, op1 0, op2 0.
`ifndef VIP_REGS_SVH
`define VIP_REGS_SVH

// ==========================================
// Coprocessor transfer encodings
`define VIP_INJ_CRN 4'hc
`define VIP_INJ_CRM 4'h1
`define VIP_INJ_OP1 3'h0
`define VIP_INJ_OP2 3'h1
`define VIP_PWR_CRN 4'hf
`define VIP_PWR_CRM 4'h0
`define VIP_PWR_OP1 3'h0
`define VIP_PWR_OP2 3'h0

// ==========================================
// Field positions
`define VIP_INJ_ABORT_BIT 8
`define VIP_INJ_IRQ_BIT 7
`define VIP_INJ_FIQ_BIT 6
`define VIP_PWR_LAT_LSB 8
`define VIP_PWR_LAT_MSB 10
`define VIP_PWR_GATE_BIT 0
`define VIP_INJ_MASK 32'h000001c0
`define VIP_PWR_MASK 32'h00000701

// ==========================================
// Reset values
`define VIP_INJ_RST 3'h0
`define VIP_GATE_RST 1'h0
`define VIP_LAT_RST 3'h0
`define VIP_WORD_ZERO 32'h00000000

`endif

/* shared/vip_pkg.sv */
// Types shared by the virtual interrupt and power register bank
package vip_pkg;

   // ==========================================
   // Register selected by a transfer
   typedef enum logic [1:0]
   {
      VIP_SEL_NONE = 2'b00,
      VIP_SEL_INJ = 2'b01,
      VIP_SEL_PWR = 2'b10
   } vip_sel_t;

   // Bit order of the three virtual events
   typedef enum logic [1:0]
   {
      VIP_EV_FIQ = 2'b00,
      VIP_EV_IRQ = 2'b01,
      VIP_EV_ABORT = 2'b10
   } vip_event_t;

endpackage

/* verilog/vip_cp_decode.sv */
// Decode of a coprocessor transfer encoding into a register select
`timescale 1ns/10ps
`include "vip_regs.svh"

module vip_cp_decode
(
   // Transfer encoding
   input wire logic [3:0] i_crn,
   input wire logic [3:0] i_crm,
   input wire logic [2:0] i_op1,
   input wire logic [2:0] i_op2,
   // Select
   output vip_pkg::vip_sel_t o_sel
);

   function automatic logic enc_match(input logic [3:0] crn, input logic [3:0] crm,
                                      input logic [2:0] op1, input logic [2:0] op2,
                                      input logic [3:0] want_crn, input logic [3:0] want_crm,
                                      input logic [2:0] want_op1, input logic [2:0] want_op2);
      enc_match = (crn == want_crn) && (crm == want_crm) && (op1 == want_op1)
                  && (op2 == want_op2);
   endfunction

   always_comb
   begin
      o_sel = vip_pkg::VIP_SEL_NONE;
      if (enc_match(i_crn, i_crm, i_op1, i_op2, `VIP_INJ_CRN, `VIP_INJ_CRM, `VIP_INJ_OP1,
                    `VIP_INJ_OP2))
      begin
         o_sel = vip_pkg::VIP_SEL_INJ;
      end
      else if (enc_match(i_crn, i_crm, i_op1, i_op2, `VIP_PWR_CRN, `VIP_PWR_CRM,
                         `VIP_PWR_OP1, `VIP_PWR_OP2))
      begin
         o_sel = vip_pkg::VIP_SEL_PWR;
      end
   end

endmodule

/* verilog/vip_event_gate.sv */
// Qualifies pending virtual events with the Non-secure state
`timescale 1ns/10ps

module vip_event_gate
#(
   parameter int N_EV = 3
)
(
   // Pending events and state
   input wire logic [N_EV-1:0] i_pending,
   input wire logic i_nonsecure,
   // Events presented to the core
   output wire logic [N_EV-1:0] o_take
);

   if (N_EV < 1)
   begin : g_bad_count
      $error("N_EV must be at least one");
   end

   for (genvar g = 0; g < N_EV; g++)
   begin : g_ev
      // No extra qualifier: the event follows the state directly
      assign o_take[g] = i_pending[g] & i_nonsecure;
   end

endmodule

/* sim/vip_bank_tb_top.sv */
// Self-checking bench for the virtual interrupt and power register bank
`timescale 1ns/10ps
`include "vip_regs.svh"

`define CHK(what, exp, got) \
   begin \
      n_tests++; \
      if ((got) !== (exp)) \
      begin \
         $display("unexpected %s: expected %h seen %h", what, exp, got); \
         fails++; \
      end \
   end

module vip_bank_tb_top;
   // ==========================================
   // Signals
   logic i_clk = 1'b0;
   logic i_srst = 1'b1;
   logic i_ce = 1'b1;
   logic i_cp_valid = 1'b0;
   logic i_cp_write = 1'b0;
   logic [3:0] i_cp_crn = 4'h0;
   logic [3:0] i_cp_crm = 4'h0;
   logic [2:0] i_cp_op1 = 3'h0;
   logic [2:0] i_cp_op2 = 3'h0;
   logic [31:0] i_cp_wdata = 32'h00000000;
   logic i_secure = 1'b1;
   logic i_priv = 1'b1;
   logic [2:0] i_max_clock_latency_pins = 3'h5;
   logic o_cp_ack;
   logic o_cp_undef;
   logic [31:0] o_cp_rdata;
   logic o_virt_abort;
   logic o_virt_irq;
   logic o_virt_fiq;
   logic o_clk_gate_en;
   logic [2:0] o_max_clk_latency;
   int fails = 0;
   int n_tests = 0;
   int cycles = 0;

   vip_bank #(.LAT_W(3)) dut
   (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_ce(i_ce),
      .i_cp_valid(i_cp_valid),
      .i_cp_write(i_cp_write),
      .i_cp_crn(i_cp_crn),
      .i_cp_crm(i_cp_crm),
      .i_cp_op1(i_cp_op1),
      .i_cp_op2(i_cp_op2),
      .i_cp_wdata(i_cp_wdata),
      .i_secure(i_secure),
      .i_priv(i_priv),
      .i_max_clock_latency_pins(i_max_clock_latency_pins),
      .o_cp_ack(o_cp_ack),
      .o_cp_undef(o_cp_undef),
      .o_cp_rdata(o_cp_rdata),
      .o_virt_abort(o_virt_abort),
      .o_virt_irq(o_virt_irq),
      .o_virt_fiq(o_virt_fiq),
      .o_clk_gate_en(o_clk_gate_en),
      .o_max_clk_latency(o_max_clk_latency)
   );

   // ==========================================
   // Clock and timeout
   initial
   begin
      forever #5 i_clk = ~i_clk;
   end

   // Whole run needs about a hundred and ten cycles; the ceiling leaves ample slack
   always @(posedge i_clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         fails++;
         wrap_up();
      end
   end

   // ==========================================
   // Tasks
   task automatic wrap_up;
      $display("tests %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask

   // State change lands on o_virt_* at the next edge; the task waits two
   task automatic mode(input logic sec, input logic prv);
      @(posedge i_clk);
      i_secure <= sec;
      i_priv <= prv;
      settle(2);
   endtask

   // One transfer: request held for one enabled edge, answer checked next cycle
   task automatic cp(input logic wr, input logic [3:0] crn, input logic [3:0] crm,
      input logic [2:0] op1, input logic [2:0] op2, input logic [31:0] wd,
      input logic exp_undef, input logic [31:0] exp_rd);
      @(posedge i_clk);
      i_cp_valid <= 1'b1;
      i_cp_write <= wr;
      i_cp_crn <= crn;
      i_cp_crm <= crm;
      i_cp_op1 <= op1;
      i_cp_op2 <= op2;
      i_cp_wdata <= wd;
      @(posedge i_clk);
      i_cp_valid <= 1'b0;
      #1;
      `CHK("ack", 1'b1, o_cp_ack)
      `CHK("undef", exp_undef, o_cp_undef)
      `CHK("rdata", exp_rd, o_cp_rdata)
   endtask

   task automatic inj(input logic wr, input logic [31:0] wd, input logic u,
      input logic [31:0] rd);
      cp(wr, `VIP_INJ_CRN, `VIP_INJ_CRM, `VIP_INJ_OP1, `VIP_INJ_OP2, wd, u, rd);
   endtask

   task automatic pwr(input logic wr, input logic [31:0] wd, input logic [31:0] rd);
      cp(wr, `VIP_PWR_CRN, `VIP_PWR_CRM, `VIP_PWR_OP1, `VIP_PWR_OP2, wd, 1'b0, rd);
   endtask

   // ==========================================
   // Sequence
   initial
   begin
      repeat (12) @(posedge i_clk);
      i_srst <= 1'b0;
      #1;
      `CHK("gate in reset", 1'b0, o_clk_gate_en)
      `CHK("latency in reset", 3'h0, o_max_clk_latency)
      settle(3);
      `CHK("latency strap", 3'h5, o_max_clk_latency)
      `CHK("gate after reset", 1'b0, o_clk_gate_en)
      pwr(1'b0, 32'h00000000, 32'h00000500);
      // Reserved bits all ones; the latency field is written back as read
      pwr(1'b1, 32'hfffffdff, 32'h00000000);
      `CHK("gate set", 1'b1, o_clk_gate_en)
      `CHK("latency kept", 3'h5, o_max_clk_latency)
      pwr(1'b0, 32'h00000000, 32'h00000501);
      settle(1);
      `CHK("ack one cycle", 1'b0, o_cp_ack)
      // Non-secure may read but not write; user writes are ignored as well
      mode(1'b0, 1'b1);
      pwr(1'b1, 32'h00000500, 32'h00000000);
      pwr(1'b0, 32'h00000000, 32'h00000501);
      mode(1'b1, 1'b0);
      pwr(1'b1, 32'h00000500, 32'h00000000);
      pwr(1'b0, 32'h00000000, 32'h00000501);
      mode(1'b1, 1'b1);
      pwr(1'b1, 32'h00000500, 32'h00000000);
      `CHK("gate cleared", 1'b0, o_clk_gate_en)
      // Virtual events held back while Secure, all three once Non-secure
      inj(1'b1, 32'hffffffff, 1'b0, 32'h00000000);
      inj(1'b0, 32'h00000000, 1'b0, 32'h000001c0);
      settle(1);
      `CHK("events secure", 3'h0, {o_virt_abort, o_virt_irq, o_virt_fiq})
      mode(1'b0, 1'b1);
      `CHK("events ns", 3'h7, {o_virt_abort, o_virt_irq, o_virt_fiq})
      inj(1'b0, 32'h00000000, 1'b1, 32'h00000000);
      inj(1'b1, 32'h00000000, 1'b1, 32'h00000000);
      settle(2);
      `CHK("ns write refused", 3'h7, {o_virt_abort, o_virt_irq, o_virt_fiq})
      mode(1'b1, 1'b0);
      inj(1'b0, 32'h00000000, 1'b1, 32'h00000000);
      mode(1'b1, 1'b1);
      inj(1'b0, 32'h00000000, 1'b0, 32'h000001c0);
      for (int i = 0; i < 3; i++)
      begin
         inj(1'b1, 32'h00000040 << i, 1'b0, 32'h00000000);
         mode(1'b0, 1'b1);
         `CHK("single event", 3'h1 << i, {o_virt_abort, o_virt_irq, o_virt_fiq})
         mode(1'b1, 1'b1);
         `CHK("event off", 3'h0, {o_virt_abort, o_virt_irq, o_virt_fiq})
      end
      // Clock enable low freezes answers, state and events; abort alone is pending
      @(posedge i_clk);
      i_ce <= 1'b0;
      i_secure <= 1'b0;
      i_cp_valid <= 1'b1;
      i_cp_write <= 1'b1;
      i_cp_crn <= `VIP_PWR_CRN;
      i_cp_crm <= `VIP_PWR_CRM;
      i_cp_op1 <= `VIP_PWR_OP1;
      i_cp_op2 <= `VIP_PWR_OP2;
      i_cp_wdata <= 32'h00000501;
      settle(3);
      `CHK("frozen ack", 1'b0, o_cp_ack)
      `CHK("frozen gate", 1'b0, o_clk_gate_en)
      `CHK("frozen events", 3'h0, {o_virt_abort, o_virt_irq, o_virt_fiq})
      @(posedge i_clk);
      i_cp_valid <= 1'b0;
      i_ce <= 1'b1;
      settle(2);
      `CHK("thawed events", 3'h4, {o_virt_abort, o_virt_irq, o_virt_fiq})
      `CHK("thawed gate", 1'b0, o_clk_gate_en)
      // Second reset with other strap values: gate clears, latency reloads
      mode(1'b1, 1'b1);
      pwr(1'b1, 32'h00000501, 32'h00000000);
      @(posedge i_clk);
      i_srst <= 1'b1;
      i_max_clock_latency_pins <= 3'h2;
      settle(2);
      `CHK("gate mid reset", 1'b0, o_clk_gate_en)
      `CHK("events mid reset", 3'h0, {o_virt_abort, o_virt_irq, o_virt_fiq})
      @(posedge i_clk);
      i_srst <= 1'b0;
      settle(2);
      `CHK("latency restrap", 3'h2, o_max_clk_latency)
      // Neighbouring encodings are not part of the bank
      cp(1'b0, 4'hf, 4'h1, 3'h0, 3'h0, 32'h00000000, 1'b1, 32'h00000000);
      cp(1'b0, 4'hc, 4'h1, 3'h0, 3'h0, 32'h00000000, 1'b1, 32'h00000000);
      wrap_up();
   end
endmodule
